// ==== hw/adc_frontend_clock_select.sv ====
// Front-end control: input mux, gain, clock source and modulator clock
`timescale 1ns/10ps
`default_nettype none
module adc_frontend_clock_select
  import frontend_pkg::*;
(
  // Clock, reset, enable
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Mux configuration
  input wire logic cfg_we,
  input wire logic [3:0] cfg_pos_sel,
  input wire logic [3:0] cfg_neg_sel,
  input wire logic [2:0] cfg_exc_chan,
  input wire logic cfg_exc_en,
  input wire logic cfg_bias_en,
  input wire logic [7:0] cfg_gpio_en,
  input wire logic [7:0] cfg_gpio_dir_out,
  input wire logic [7:0] cfg_gpio_out,
  input wire logic [2:0] cfg_gain,
  input wire logic [3:0] cfg_rate,
  // Pins
  input wire logic clk_pin,
  input wire logic [7:0] ain_pin_in,
  output logic [7:0] ain_pin_out,
  output logic [7:0] ain_pin_oe_n,
  // Modulator stream
  input wire logic mod_bit,
  // Analog switch controls and status
  output logic [7:0] pos_pin_switch,
  output logic [7:0] neg_pin_switch,
  output logic [3:0] monitor_switch,
  output logic [7:0] exc_switch,
  output logic [7:0] bias_switch,
  output logic [7:0] gpio_in,
  output logic [7:0] gain_onehot,
  output logic [11:0] full_scale_range,
  output logic [7:0] modulator_clock_rate,
  output logic use_ext_clk,
  output logic filter_bit,
  output logic filter_bit_valid
);
  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  logic [3:0] pos_reg, neg_reg, rate_reg;
  logic [2:0] gain_reg, exc_reg;
  logic exc_en_reg, bias_en_reg;
  logic [7:0] gpio_en_reg, gpio_dir_reg, gpio_out_reg;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pos_reg <= POS_RESET;
      neg_reg <= NEG_RESET;
      rate_reg <= RATE_RESET;
      gain_reg <= GAIN_RESET;
      exc_reg <= 3'h0;
      exc_en_reg <= 1'b0;
      bias_en_reg <= 1'b0;
      gpio_en_reg <= 8'h00;
      gpio_dir_reg <= 8'h00;
      gpio_out_reg <= 8'h00;
    end else if (ce && cfg_we) begin
      pos_reg <= cfg_pos_sel;
      neg_reg <= cfg_neg_sel;
      rate_reg <= cfg_rate;
      gain_reg <= cfg_gain;
      exc_reg <= cfg_exc_chan;
      exc_en_reg <= cfg_exc_en;
      bias_en_reg <= cfg_bias_en;
      gpio_en_reg <= cfg_gpio_en;
      gpio_dir_reg <= cfg_gpio_dir_out;
      gpio_out_reg <= cfg_gpio_out;
    end
  end

  // ----------------------------------------
  // Selection decode
  // ----------------------------------------
  wire logic pos_is_pin = (pos_reg[3] == 1'b0);
  wire logic neg_is_pin = (neg_reg[3] == 1'b0);
  wire logic [7:0] pos_dec = pos_is_pin ? (8'h01 << pos_reg[2:0]) : 8'h00;
  wire logic [7:0] neg_dec = neg_is_pin ? (8'h01 << neg_reg[2:0]) : 8'h00;
  wire logic [3:0] mon_dec;
  // Monitor sources are decoded from the positive selection only
  assign mon_dec[0] = (pos_reg == SRC_TEMP);
  assign mon_dec[1] = (pos_reg == SRC_AVDD);
  assign mon_dec[2] = (pos_reg == SRC_DVDD);
  assign mon_dec[3] = (pos_reg == SRC_EXTREF);
  wire logic [7:0] chan_dec = 8'h01 << exc_reg;
  // Pins given to GPIO never see analog switches
  wire logic [7:0] analog_ok = ~gpio_en_reg;
  wire logic [7:0] exc_dec = exc_en_reg ? chan_dec & analog_ok : 8'h00;
  wire logic [7:0] bias_dec = bias_en_reg ? chan_dec & analog_ok : 8'h00;
  wire logic [7:0] gain_dec = 8'h01 << gain_reg;
  wire logic [11:0] fsr_dec = FSR_GAIN1_MV >> gain_reg;
  wire logic [7:0] ratio_dec =
    (rate_reg <= RATE_20) ? DIV_SLOW :
    (rate_reg <= RATE_160) ? DIV_MID :
    (rate_reg <= RATE_1000) ? DIV_FAST : DIV_MAX;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [7:0] gpio_s1_reg, gpio_s2_reg;
  logic clk_s1_reg, clk_s2_reg, clk_s3_reg;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      gpio_s1_reg <= 8'h00;
      gpio_s2_reg <= 8'h00;
      clk_s1_reg <= 1'b0;
      clk_s2_reg <= 1'b0;
      clk_s3_reg <= 1'b0;
    end else if (ce) begin
      gpio_s1_reg <= ain_pin_in;
      gpio_s2_reg <= gpio_s1_reg;
      clk_s1_reg <= clk_pin;
      clk_s2_reg <= clk_s1_reg;
      clk_s3_reg <= clk_s2_reg;
    end
  end
  wire logic clk_rise = clk_s2_reg & ~clk_s3_reg;

  // ----------------------------------------
  // Clock source selection
  // ----------------------------------------
  // Boot reads clk_s2_reg on the first enabled edge after reset, while it still holds its reset 0, never during reset
  clk_state_t state_reg, state_next;
  logic [1:0] edge_reg, edge_next;
  always_comb begin
    state_next = state_reg;
    edge_next = edge_reg;
    unique case (state_reg)
      CLK_BOOT: begin
        state_next = clk_s2_reg ? CLK_EXTERNAL : CLK_INTERNAL;
      end
      CLK_INTERNAL: begin
        // A few edges filter a single glitch on an idle pin
        if (clk_rise) begin
          edge_next = edge_reg + 2'h1;
          if (edge_reg + 2'h1 == EXT_EDGES) begin
            state_next = CLK_EXTERNAL;
          end
        end
      end
      CLK_EXTERNAL: begin
        state_next = CLK_EXTERNAL;
      end
      default: begin
        state_next = CLK_BOOT;
      end
    endcase
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= CLK_BOOT;
      edge_reg <= 2'h0;
    end else if (ce) begin
      state_reg <= state_next;
      edge_reg <= edge_next;
    end
  end

  // ----------------------------------------
  // Modulator clock
  // ----------------------------------------
  mod_clk_if mclk ();
  assign mclk.ratio = ratio_dec;
  mod_clk_divider u_div (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .link(mclk)
  );

  // ----------------------------------------
  // Registered outputs
  // ----------------------------------------
  genvar i;
  generate
    for (i = 0; i < PIN_COUNT; i++) begin : g_pin
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          ain_pin_out[i] <= 1'b0;
          ain_pin_oe_n[i] <= 1'b1;
          gpio_in[i] <= 1'b0;
        end else if (ce) begin
          ain_pin_out[i] <= gpio_out_reg[i];
          ain_pin_oe_n[i] <= ~(gpio_en_reg[i] & gpio_dir_reg[i]);
          gpio_in[i] <= gpio_en_reg[i] & gpio_s2_reg[i];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pos_pin_switch <= 8'h00;
      neg_pin_switch <= 8'h00;
      monitor_switch <= 4'h0;
      exc_switch <= 8'h00;
      bias_switch <= 8'h00;
      gain_onehot <= 8'h01;
      full_scale_range <= FSR_GAIN1_MV;
      modulator_clock_rate <= DIV_SLOW;
      use_ext_clk <= 1'b0;
      filter_bit <= 1'b0;
      filter_bit_valid <= 1'b0;
    end else if (ce) begin
      pos_pin_switch <= pos_dec & analog_ok;
      neg_pin_switch <= neg_dec & analog_ok;
      monitor_switch <= mon_dec;
      exc_switch <= exc_dec;
      bias_switch <= bias_dec;
      gain_onehot <= gain_dec;
      full_scale_range <= fsr_dec;
      modulator_clock_rate <= ratio_dec;
      use_ext_clk <= (state_reg == CLK_EXTERNAL);
      filter_bit_valid <= mclk.tick;
      if (mclk.tick) begin
        filter_bit <= mod_bit;
      end
    end
  end
endmodule
`default_nettype wire

// ==== pkg/frontend_pkg.sv ====
// Constants and types for the converter front-end control block
package frontend_pkg;
  localparam int PIN_COUNT = 8;
  localparam int SEL_W = 3;
  localparam int GAIN_W = 3;
  localparam int RATE_W = 4;
  // Input selection codes: 0..7 pins, then monitor sources
  localparam int SRC_W = 4;
  localparam logic [3:0] SRC_TEMP = 4'h8;
  localparam logic [3:0] SRC_AVDD = 4'h9;
  localparam logic [3:0] SRC_DVDD = 4'hA;
  localparam logic [3:0] SRC_EXTREF = 4'hB;
  // Data rate codes, 5 SPS .. 2000 SPS
  localparam logic [3:0] RATE_20 = 4'h2;
  localparam logic [3:0] RATE_160 = 4'h5;
  localparam logic [3:0] RATE_1000 = 4'h8;
  // Divide ratios and full-scale at gain 1 in millivolts
  localparam logic [7:0] DIV_SLOW = 8'h80;
  localparam logic [7:0] DIV_MID = 8'h20;
  localparam logic [7:0] DIV_FAST = 8'h10;
  localparam logic [7:0] DIV_MAX = 8'h08;
  localparam logic [11:0] FSR_GAIN1_MV = 12'h800;
  localparam int NOMINAL_CLK_HZ = 4096000;
  // Clock pin edges needed to trust an external clock
  localparam logic [1:0] EXT_EDGES = 2'h3;
  // Reset values
  localparam logic [3:0] POS_RESET = 4'h0;
  localparam logic [3:0] NEG_RESET = 4'h1;
  localparam logic [3:0] RATE_RESET = 4'h0;
  localparam logic [2:0] GAIN_RESET = 3'h0;
  typedef enum logic [1:0] {
    CLK_BOOT = 2'b00,
    CLK_INTERNAL = 2'b01,
    CLK_EXTERNAL = 2'b11
  } clk_state_t;
endpackage

// ==== pkg/mod_clk_if.sv ====
// Carrier between front-end top and modulator clock divider
`timescale 1ns/10ps
`default_nettype none
interface mod_clk_if;
  logic [7:0] ratio;
  logic tick;
  modport ctrl (output ratio, input tick);
  modport div (input ratio, output tick);
endinterface
`default_nettype wire

// ==== hw/mod_clk_divider.sv ====
// Modulator clock divider producing one tick per divide period
`timescale 1ns/10ps
`default_nettype none
module mod_clk_divider
  import frontend_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Ratio in, tick out
  mod_clk_if.div link
);
  logic [7:0] count_reg;
  logic [7:0] count_next;
  wire logic at_end = (count_reg >= link.ratio - 8'h01);
  assign count_next = at_end ? 8'h00 : count_reg + 8'h01;
  assign link.tick = at_end;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count_reg <= 8'h00;
    end else if (ce) begin
      count_reg <= count_next;
    end
  end
endmodule
`default_nettype wire

// ==== verification/frontend_monitor.sv ====
// Checker for the front-end control block, bound to its top
`timescale 1ns/10ps
`default_nettype none
module frontend_monitor
  import frontend_pkg::*;
(
  // Clock and configuration
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic cfg_we,
  input wire logic [3:0] cfg_pos_sel,
  input wire logic [7:0] cfg_gpio_en,
  input wire logic [7:0] cfg_gpio_dir_out,
  input wire logic [2:0] cfg_gain,
  input wire logic [3:0] cfg_rate,
  input wire logic clk_pin,
  // Watched outputs
  input wire logic [7:0] ain_pin_oe_n,
  input wire logic [7:0] pos_pin_switch,
  input wire logic [3:0] monitor_switch,
  input wire logic [7:0] gain_onehot,
  input wire logic [11:0] full_scale_range,
  input wire logic [7:0] modulator_clock_rate,
  input wire logic use_ext_clk,
  input wire logic filter_bit_valid
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Write edge plus the enabled edge of the register stage
  sequence s_wr; ce && cfg_we ##1 ce; endsequence
  function automatic logic [7:0] div(input logic [3:0] r);
    return r <= RATE_20 ? DIV_SLOW : r <= RATE_160 ? DIV_MID :
      r <= RATE_1000 ? DIV_FAST : DIV_MAX;
  endfunction
  a_pos_pick: assert property (cfg_gpio_en == 8'h00 ##0 s_wr |=>
    pos_pin_switch == 8'h01 << $past(cfg_pos_sel, 2)) else $error("pos");
  a_mon_pick: assert property (cfg_pos_sel inside {[4'h8:4'hB]} ##0 s_wr |=>
    monitor_switch == 4'h1 << ($past(cfg_pos_sel, 2) - 4'h8)) else $error("mon");
  a_gpio_oe: assert property (s_wr |=> ain_pin_oe_n ==
    ~($past(cfg_gpio_en, 2) & $past(cfg_gpio_dir_out, 2))) else $error("oe");
  a_gain_code: assert property (s_wr |=>
    gain_onehot == 8'h01 << $past(cfg_gain, 2)) else $error("gain");
  a_fsr_gain: assert property ({8'h00, full_scale_range} *
    {12'h000, gain_onehot} == 20'h00800) else $error("fsr");
  a_rate_div: assert property (cfg_rate <= 4'h9 ##0 s_wr |=>
    modulator_clock_rate == div($past(cfg_rate, 2))) else $error("ratio");
  // A frozen pulse only resumes counting once ce is back at the start edge
  a_fast_tick: assert property (ce && filter_bit_valid && modulator_clock_rate ==
    DIV_MAX ##1 (ce && $stable(modulator_clock_rate))[*7] |=> filter_bit_valid)
    else $error("spacing");
  a_ext_sticky: assert property (use_ext_clk |=> use_ext_clk)
    else $error("sticky");
  a_int_held: assert property ((!clk_pin)[*8] |-> !$rose(use_ext_clk))
    else $error("internal");
  a_ext_seen: assert property ($rose(clk_pin) ##[1:8] $rose(clk_pin)
    ##[1:8] $rose(clk_pin) |-> ##[0:8] use_ext_clk) else $error("external");
  c_ext: cover property ($rose(use_ext_clk));
  c_fast: cover property (filter_bit_valid && modulator_clock_rate == DIV_MAX);
  c_mon: cover property (monitor_switch != 4'h0);
endmodule
bind adc_frontend_clock_select frontend_monitor mon (.clk, .rst, .ce,
  .cfg_we, .cfg_pos_sel, .cfg_gpio_en, .cfg_gpio_dir_out, .cfg_gain,
  .cfg_rate, .clk_pin, .ain_pin_oe_n, .pos_pin_switch, .monitor_switch,
  .gain_onehot, .full_scale_range, .modulator_clock_rate, .use_ext_clk,
  .filter_bit_valid);
`default_nettype wire

// ==== verification/sensor_model.sv ====
// Sensors and clock source on the far side of the front-end pins
`timescale 1ns/10ps
`default_nettype none
module sensor_model (
  // Bench control
  input wire logic ext_on,
  input wire logic [7:0] level,
  // Pins
  input wire logic [7:0] ain_pin_out,
  input wire logic [7:0] ain_pin_oe_n,
  output logic [7:0] ain_pin_in,
  output var logic clk_pin
);
  // Driven pins read back; released pins show the sensor level
  assign ain_pin_in = (~ain_pin_oe_n & ain_pin_out) |
    (ain_pin_oe_n & level);
  // Grounded when idle, free-running and unrelated to clk when on
  initial clk_pin = 1'b0;
  always #37 clk_pin = ext_on & ~clk_pin;
endmodule
`default_nettype wire

// ==== verification/testbench.sv ====
// Self-checking bench for the front-end control block
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic clk = 1'b0, rst = 1'b1, ce = 1'b1, cfg_we = 1'b0, mod_bit = 1'b1;
  logic cfg_exc_en = 1'b0, cfg_bias_en = 1'b0, ext_on = 1'b0;
  logic [3:0] cfg_pos_sel = 4'h0, cfg_neg_sel = 4'h1, cfg_rate = 4'h0;
  logic [2:0] cfg_exc_chan = 3'h0, cfg_gain = 3'h0;
  logic [7:0] cfg_gpio_en = 8'h00, cfg_gpio_dir_out = 8'h00;
  logic [7:0] cfg_gpio_out = 8'h00, level = 8'hA5;
  logic [7:0] ain_pin_out, ain_pin_oe_n, pos_pin_switch, neg_pin_switch;
  logic [7:0] exc_switch, bias_switch, gpio_in, gain_onehot;
  logic [7:0] modulator_clock_rate;
  logic [3:0] monitor_switch;
  logic [11:0] full_scale_range;
  logic use_ext_clk, filter_bit, filter_bit_valid;
  wire clk_pin;
  wire [7:0] ain_pin_in;
  logic [7:0] ratio_exp [10] = '{8'h80, 8'h80, 8'h80, 8'h20, 8'h20,
    8'h20, 8'h10, 8'h10, 8'h10, 8'h08};
  int n_fail = 0, n_checks = 0, cyc = 0, k;
  adc_frontend_clock_select dut (.clk, .rst, .ce, .cfg_we, .cfg_pos_sel,
    .cfg_neg_sel, .cfg_exc_chan, .cfg_exc_en, .cfg_bias_en, .cfg_gpio_en,
    .cfg_gpio_dir_out, .cfg_gpio_out, .cfg_gain, .cfg_rate, .clk_pin,
    .ain_pin_in, .ain_pin_out, .ain_pin_oe_n, .mod_bit, .pos_pin_switch,
    .neg_pin_switch, .monitor_switch, .exc_switch, .bias_switch, .gpio_in,
    .gain_onehot, .full_scale_range, .modulator_clock_rate, .use_ext_clk,
    .filter_bit, .filter_bit_valid);
  sensor_model far (.ext_on, .level, .ain_pin_out, .ain_pin_oe_n,
    .ain_pin_in, .clk_pin);
  always #12.5 clk = ~clk;
  // Run is under 1000 cycles; the ceiling leaves wide margin
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      wrap_up();
    end
  end
  task automatic chk(input logic [11:0] s, input logic [11:0] e);
    n_checks++;
    if (s !== e) begin
      n_fail++;
      $display("BAD %0t %h %h", $time, s, e);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d fails %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Outputs settle one edge after the write edge; one spare cycle follows
  task automatic wr;
    @(negedge clk) cfg_we = 1'b1;
    @(negedge clk) cfg_we = 1'b0;
    repeat (2) @(negedge clk);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    chk(gain_onehot, 8'h01);
    chk(full_scale_range, 12'h800);
    chk(modulator_clock_rate, 8'h80);
    chk(ain_pin_oe_n, 8'hFF);
  endtask
  task automatic t_mux;
    for (int i = 0; i < 12; i++) begin
      cfg_pos_sel = 4'(i);
      cfg_neg_sel = 4'(7 - i);
      wr();
      chk(pos_pin_switch, i < 8 ? 8'h01 << i : 8'h00);
      chk(neg_pin_switch, i < 8 ? 8'h80 >> i : 8'h00);
      chk(monitor_switch, i < 8 ? 4'h0 : 4'h1 << (i - 8));
    end
  endtask
  task automatic t_gain_rate;
    for (int i = 0; i < 10; i++) begin
      cfg_gain = 3'(i);
      cfg_rate = 4'(i);
      wr();
      chk(gain_onehot, 8'h01 << (i % 8));
      chk(full_scale_range, 12'h800 >> (i % 8));
      chk(modulator_clock_rate, ratio_exp[i]);
    end
    for (k = 0; k < 300 && filter_bit_valid !== 1'b1; k++) @(negedge clk);
    chk(filter_bit, 1'b1);
    @(negedge clk) mod_bit = 1'b0;
    for (k = 1; k < 300 && filter_bit_valid !== 1'b1; k++) @(negedge clk);
    chk(12'(k), 12'h008);
    chk(filter_bit, 1'b0);
  endtask
  task automatic t_gpio;
    cfg_gpio_en = 8'h0F;
    cfg_gpio_dir_out = 8'h03;
    cfg_gpio_out = 8'h02;
    cfg_pos_sel = 4'h0;
    cfg_neg_sel = 4'h4;
    cfg_exc_chan = 3'h5;
    cfg_exc_en = 1'b1;
    cfg_bias_en = 1'b1;
    wr();
    repeat (4) @(negedge clk);
    chk(ain_pin_oe_n, 8'hFC);
    chk(ain_pin_out & 8'h03, 8'h02);
    chk(gpio_in & 8'hFC, 8'h04);
    chk(pos_pin_switch, 8'h00);
    chk(neg_pin_switch, 8'h10);
    chk(exc_switch, 8'h20);
    chk(bias_switch, 8'h20);
    cfg_exc_chan = 3'h2;
    wr();
    chk(exc_switch, 8'h00);
  endtask
  // Clock enable low must ignore a write; the same write lands once high
  task automatic t_freeze;
    ce = 1'b0;
    cfg_gain = 3'h5;
    wr();
    chk(gain_onehot, 8'h02);
    chk(full_scale_range, 12'h400);
    ce = 1'b1;
    wr();
    chk(gain_onehot, 8'h20);
    chk(full_scale_range, 12'h040);
  endtask
  task automatic t_clk;
    chk(use_ext_clk, 1'b0);
    ext_on = 1'b1;
    repeat (40) @(negedge clk);
    chk(use_ext_clk, 1'b1);
    ext_on = 1'b0;
    repeat (20) @(negedge clk);
    chk(use_ext_clk, 1'b1);
    rst = 1'b1;
    @(negedge clk);
    chk(use_ext_clk, 1'b0);
    rst = 1'b0;
    repeat (10) @(negedge clk);
    chk(use_ext_clk, 1'b0);
  endtask
  initial begin
    repeat (2) @(negedge clk);
    t_reset();
    rst = 1'b0;
    t_mux();
    t_gain_rate();
    t_gpio();
    t_freeze();
    t_clk();
    wrap_up();
  end
endmodule
`default_nettype wire
